// *** rtl/hcar_map.vh ***
`ifndef HCAR_MAP_VH
`define HCAR_MAP_VH
// Brake pattern select codes
`define HCAR_BRK_LOW 2'h0
`define HCAR_BRK_HIGH 2'h1
`define HCAR_BRK_ALT 2'h2
`define HCAR_BRK_HIZ 2'h3
// Commutation mode select
`define HCAR_MODE_SIX 1'h0
`define HCAR_MODE_ALT 1'h1
// Freewheel select
`define HCAR_FW_DIODE 1'h0
`define HCAR_FW_ACTIVE 1'h1
// Per-phase drive codes
`define HCAR_PH_FLOAT 2'h0
`define HCAR_PH_PWM 2'h1
`define HCAR_PH_ON 2'h2
`define HCAR_PH_LPWM 2'h3
// Dead time counter width and defaults
`define HCAR_DT_W 8
`define HCAR_DT_RST 8'h00
// Rotation progress width
`define HCAR_STEP_W 3
`define HCAR_STEP_FULL 3'h6
`endif

// *** rtl/hcar_dead_time.v ***
`timescale 1ns/1ps
`default_nettype none
`include "hcar_map.vh"
// Delays each rising gate request by a programmed count; falls pass at once
module hcar_dead_time (
  input wire clk_i,
  input wire reset_n_i,
  input wire [`HCAR_DT_W-1:0] dead_time_i,
  input wire high_req_i,
  input wire low_req_i,
  output reg high_o,
  output reg low_o
);
  reg [`HCAR_DT_W-1:0] cnt_r;
  reg last_high_r;
  reg last_low_r;
  // ------------------------------------------------------------
  // Dead time gap
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= `HCAR_DT_RST;
      high_o <= 1'b0;
      low_o <= 1'b0;
      last_high_r <= 1'b0;
      last_low_r <= 1'b0;
    end else begin
      last_high_r <= high_req_i;
      last_low_r <= low_req_i;
      if ((high_req_i != last_high_r) || (low_req_i != last_low_r)) begin
        cnt_r <= dead_time_i;
      end else if (cnt_r != `HCAR_DT_RST) begin
        cnt_r <= cnt_r - 8'h01;
      end
      high_o <= high_req_i & high_o | high_req_i & ~low_o & (cnt_r == `HCAR_DT_RST)
        & (high_req_i == last_high_r);
      low_o <= low_req_i & low_o | low_req_i & ~high_o & (cnt_r == `HCAR_DT_RST)
        & (low_req_i == last_low_r);
    end
  end
endmodule // hcar_dead_time
`default_nettype wire

// *** rtl/hcar_commutator.v ***
// Notes on behaviour
// - Modulated gates take timing only from the single PWM input.
// - Three Hall levels choose modulated, held-on and floating phases.
// - Direction input picks its own Hall-to-gate mapping for each level.
// - Brake input low forces the brake pattern on all six gates.
// - Brake pattern: all low on, all high on, alternating, or all off.
// - Freewheel select picks diode or active freewheeling in both modes.
// - Diode freewheeling holds low any gate that would carry inverted PWM.
// - Floating phase keeps both its gates low.
// - Alternating mode moves recirculation between high and low switches.
// - First rotation: driven high side modulated, return low side on.
// - Second rotation: low side modulated, high side on, complement inverted.
// - Alternating mode has twelve states, six high-mod then six low-mod.
// - After the twelfth state the machine wraps to the first.
// - Dead time inserted between complementary gates from programmed fields.
// - Alternating braking swaps high and low braking per brake event.
// - Releasing brake resumes normal gate propagation.
`timescale 1ns/1ps
`default_nettype none
`include "hcar_map.vh"
module hcar_commutator (
  input wire clk_i,
  input wire reset_n_i,
  input wire pwm_in_phase_a_high_i,
  input wire hall_in_sensor_a_i,
  input wire hall_in_sensor_b_i,
  input wire hall_in_sensor_c_i,
  input wire direction_select_in_i,
  input wire brake_request_n_i,
  input wire alt_recirc_enable_i,
  input wire freewheel_type_select_i,
  input wire [1:0] brake_pattern_select_i,
  input wire [`HCAR_DT_W-1:0] dead_time_rising_i,
  input wire [`HCAR_DT_W-1:0] dead_time_hall_mode_i,
  output reg gate_high_phase_a_o,
  output reg gate_low_phase_a_o,
  output reg gate_high_phase_b_o,
  output reg gate_low_phase_b_o,
  output reg gate_high_phase_c_o,
  output reg gate_low_phase_c_o,
  output reg low_side_modulation_o,
  output reg brake_active_o
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync1_r <= 6'h20;
      sync2_r <= 6'h20;
    end else begin
      sync1_r <= {brake_request_n_i, direction_select_in_i, pwm_in_phase_a_high_i,
        hall_in_sensor_a_i, hall_in_sensor_b_i, hall_in_sensor_c_i};
      sync2_r <= sync1_r;
    end
  end
  wire [2:0] hall_w = sync2_r[2:0];
  wire pwm_w = sync2_r[3];
  wire dir_w = sync2_r[4];
  wire brake_n_w = sync2_r[5];
  wire hall_ok_w = (hall_w != 3'h0) && (hall_w != 3'h7);
  // ------------------------------------------------------------
  // Rotation tracking
  // ------------------------------------------------------------
  reg [2:0] last_hall_r;
  reg [`HCAR_STEP_W-1:0] steps_r;
  reg low_mod_r;
  reg brake_d_r;
  reg brake_alt_r;
  wire new_pat_w = hall_ok_w && (hall_w != last_hall_r);
  wire done_w = new_pat_w && (steps_r == `HCAR_STEP_FULL - 3'h1);
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      last_hall_r <= 3'h0;
      steps_r <= 3'h0;
      low_mod_r <= 1'b0;
      brake_d_r <= 1'b0;
      brake_alt_r <= 1'b0;
    end else begin
      brake_d_r <= ~brake_n_w;
      if (~brake_n_w && !brake_d_r) begin
        brake_alt_r <= ~brake_alt_r;
      end
      if (new_pat_w) begin
        last_hall_r <= hall_w;
      end
      if (!alt_recirc_enable_i) begin
        steps_r <= 3'h0;
        low_mod_r <= 1'b0;
      end else if (done_w) begin
        steps_r <= 3'h0;
        low_mod_r <= ~low_mod_r;
      end else if (new_pat_w) begin
        steps_r <= steps_r + 3'h1;
      end
    end
  end
  // ------------------------------------------------------------
  // Commutation table
  // ------------------------------------------------------------
  reg [1:0] pa;
  reg [1:0] pb;
  reg [1:0] pc;
  reg [2:0] key;
  always @* begin
    key = dir_w ? hall_w : ~hall_w;
    pa = `HCAR_PH_FLOAT;
    pb = `HCAR_PH_FLOAT;
    pc = `HCAR_PH_FLOAT;
    case (key)
      3'h5: begin pa = `HCAR_PH_PWM; pc = `HCAR_PH_ON; end
      3'h4: begin pb = `HCAR_PH_PWM; pc = `HCAR_PH_ON; end
      3'h6: begin pb = `HCAR_PH_PWM; pa = `HCAR_PH_ON; end
      3'h2: begin pc = `HCAR_PH_PWM; pa = `HCAR_PH_ON; end
      3'h3: begin pc = `HCAR_PH_PWM; pb = `HCAR_PH_ON; end
      3'h1: begin pa = `HCAR_PH_PWM; pb = `HCAR_PH_ON; end
      default: begin pa = `HCAR_PH_FLOAT; end
    endcase
    if (!hall_ok_w) begin
      pa = `HCAR_PH_FLOAT;
      pb = `HCAR_PH_FLOAT;
      pc = `HCAR_PH_FLOAT;
    end
  end
  // ------------------------------------------------------------
  // Gate requests per phase
  // ------------------------------------------------------------
  wire [5:0] ph_w = {pc, pb, pa};
  wire [2:0] req_h_w;
  wire [2:0] req_l_w;
  wire fw_act_w = (freewheel_type_select_i == `HCAR_FW_ACTIVE);
  wire low_w = low_mod_r;
  wire brk_alt_now_w = brake_d_r ? brake_alt_r : ~brake_alt_r;
  wire [1:0] bsel_w = (brake_pattern_select_i == `HCAR_BRK_ALT) ?
    (brk_alt_now_w ? `HCAR_BRK_HIGH : `HCAR_BRK_LOW) : brake_pattern_select_i;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      wire [1:0] p = ph_w[2*g+1:2*g];
      wire is_pwm_w = (p == `HCAR_PH_PWM);
      wire is_on_w = (p == `HCAR_PH_ON);
      wire h_first_w = is_pwm_w & pwm_w;
      wire l_first_w = (is_pwm_w & ~pwm_w & fw_act_w) | is_on_w;
      wire h_second_w = is_pwm_w | (is_on_w & ~pwm_w & fw_act_w);
      wire l_second_w = is_on_w & pwm_w;
      wire nh = low_w ? h_second_w : h_first_w;
      wire nl = low_w ? l_second_w : l_first_w;
      assign req_h_w[g] = brake_n_w ? nh : (bsel_w == `HCAR_BRK_HIGH);
      assign req_l_w[g] = brake_n_w ? nl : (bsel_w == `HCAR_BRK_LOW);
    end
  endgenerate
  // ------------------------------------------------------------
  // Dead time and output registers
  // ------------------------------------------------------------
  wire [2:0] dt_h_w;
  wire [2:0] dt_l_w;
  wire [`HCAR_DT_W-1:0] dt_w = (dead_time_rising_i > dead_time_hall_mode_i) ?
    dead_time_rising_i : dead_time_hall_mode_i;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_dt
      hcar_dead_time u_dt (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .dead_time_i(dt_w),
        .high_req_i(req_h_w[g]),
        .low_req_i(req_l_w[g]),
        .high_o(dt_h_w[g]),
        .low_o(dt_l_w[g])
      );
    end
  endgenerate
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      gate_high_phase_a_o <= 1'b0;
      gate_low_phase_a_o <= 1'b0;
      gate_high_phase_b_o <= 1'b0;
      gate_low_phase_b_o <= 1'b0;
      gate_high_phase_c_o <= 1'b0;
      gate_low_phase_c_o <= 1'b0;
    end else begin
      gate_high_phase_a_o <= dt_h_w[0];
      gate_low_phase_a_o <= dt_l_w[0];
      gate_high_phase_b_o <= dt_h_w[1];
      gate_low_phase_b_o <= dt_l_w[1];
      gate_high_phase_c_o <= dt_h_w[2];
      gate_low_phase_c_o <= dt_l_w[2];
    end
  end
  // ------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------
  // half and brake flags
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      low_side_modulation_o <= 1'b0;
      brake_active_o <= 1'b0;
    end else begin
      low_side_modulation_o <= low_mod_r;
      brake_active_o <= ~brake_n_w;
    end
  end
endmodule // hcar_commutator
`default_nettype wire

// *** tb/hcar_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module hcar_props (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pwm_in_phase_a_high_i,
  input wire logic hall_in_sensor_a_i,
  input wire logic hall_in_sensor_b_i,
  input wire logic hall_in_sensor_c_i,
  input wire logic direction_select_in_i,
  input wire logic brake_request_n_i,
  input wire logic alt_recirc_enable_i,
  input wire logic freewheel_type_select_i,
  input wire logic [1:0] brake_pattern_select_i,
  input wire logic gate_high_phase_a_o,
  input wire logic gate_low_phase_a_o,
  input wire logic gate_high_phase_b_o,
  input wire logic gate_low_phase_b_o,
  input wire logic gate_high_phase_c_o,
  input wire logic gate_low_phase_c_o,
  input wire logic low_side_modulation_o,
  input wire logic brake_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [2:0] hall = {hall_in_sensor_a_i, hall_in_sensor_b_i, hall_in_sensor_c_i};
  wire logic [5:0] g = {gate_high_phase_a_o, gate_low_phase_a_o, gate_high_phase_b_o,
    gate_low_phase_b_o, gate_high_phase_c_o, gate_low_phase_c_o};
  wire logic run = brake_request_n_i && !alt_recirc_enable_i && direction_select_in_i
    && hall == 3'h5;
  shoot_phase_a_a: assert property (!(g[5] && g[4])) else $error("a overlap");
  shoot_phase_b_a: assert property (!(g[3] && g[2])) else $error("b overlap");
  shoot_phase_c_a: assert property (!(g[1] && g[0])) else $error("c overlap");
  brake_seen_a: assert property (!brake_request_n_i [*4] |-> brake_active_o)
    else $error("brake late");
  brake_gone_a: assert property (brake_request_n_i [*4] |-> !brake_active_o)
    else $error("brake stuck");
  brake_hiz_a: assert property ((!brake_request_n_i && brake_pattern_select_i == 2'h3)
    [*8] |-> g == 6'h00) else $error("hiz brake");
  brake_low_a: assert property ((!brake_request_n_i && brake_pattern_select_i == 2'h0)
    [*8] |-> g == 6'h15) else $error("low brake");
  bad_hall_a: assert property ((brake_request_n_i && (hall == 3'h0 || hall == 3'h7)) [*6]
    |-> g == 6'h00) else $error("bad hall");
  diode_float_a: assert property ((run && !freewheel_type_select_i) [*6]
    |-> !g[4] && g[3:2] == 2'h0) else $error("diode float");
  pwm_high_a: assert property ((run && pwm_in_phase_a_high_i) [*8] |-> g[5])
    else $error("pwm high");
  pwm_low_a: assert property ((run && !pwm_in_phase_a_high_i) [*5] |-> !g[5])
    else $error("pwm low");
  half_clear_a: assert property (!alt_recirc_enable_i [*3] |-> !low_side_modulation_o)
    else $error("half set");
  cover property (brake_active_o);
  cover property (low_side_modulation_o);
  cover property (run && g[5]);
endmodule // hcar_props
bind hcar_commutator hcar_props i_props (.clk_i, .reset_n_i, .pwm_in_phase_a_high_i,
  .hall_in_sensor_a_i, .hall_in_sensor_b_i, .hall_in_sensor_c_i, .direction_select_in_i,
  .brake_request_n_i, .alt_recirc_enable_i, .freewheel_type_select_i, .brake_pattern_select_i,
  .gate_high_phase_a_o, .gate_low_phase_a_o, .gate_high_phase_b_o, .gate_low_phase_b_o,
  .gate_high_phase_c_o, .gate_low_phase_c_o, .low_side_modulation_o, .brake_active_o);
`default_nettype wire

// *** tb/hcar_mcu.sv ***
`timescale 1ns/1ps
`default_nettype none
module hcar_mcu (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic [1:0] bad_i,
  output logic [2:0] hall_o
);
  logic [2:0] idx_r = 3'h0;
  logic [2:0] seq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  always @(negedge clk_i) begin
    if (step_i) begin
      idx_r <= dir_i ? (idx_r == 3'h5 ? 3'h0 : idx_r + 3'h1) :
        (idx_r == 3'h0 ? 3'h5 : idx_r - 3'h1);
    end
  end
  assign hall_o = bad_i == 2'h1 ? 3'h0 : bad_i == 2'h2 ? 3'h7 : seq[idx_r];
endmodule // hcar_mcu
`default_nettype wire

// *** tb/hall_commutation_alt_recirc_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module hall_commutation_alt_recirc_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pwm = 1'b0;
  logic dir = 1'b1;
  logic brk_n = 1'b1;
  logic alt = 1'b0;
  logic fw = 1'b1;
  logic [1:0] bsel = 2'h2;
  logic step = 1'b0;
  logic [1:0] bad = 2'h0;
  logic hlf = 1'b0;
  logic [5:0] bexp = 6'h00;
  logic [2:0] hall;
  wire logic [5:0] g;
  wire logic lsm;
  wire logic bact;
  int bad_count = 0;
  int checks = 0;
  always #50 clk_i = ~clk_i;
  hcar_mcu i_mcu (.clk_i(clk_i), .step_i(step), .dir_i(dir), .bad_i(bad), .hall_o(hall));
  hcar_commutator i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .pwm_in_phase_a_high_i(pwm),
    .hall_in_sensor_a_i(hall[2]), .hall_in_sensor_b_i(hall[1]), .hall_in_sensor_c_i(hall[0]),
    .direction_select_in_i(dir), .brake_request_n_i(brk_n), .alt_recirc_enable_i(alt),
    .freewheel_type_select_i(fw), .brake_pattern_select_i(bsel), .dead_time_rising_i(8'h01),
    .dead_time_hall_mode_i(8'h02), .gate_high_phase_a_o(g[5]), .gate_low_phase_a_o(g[4]),
    .gate_high_phase_b_o(g[3]), .gate_low_phase_b_o(g[2]), .gate_high_phase_c_o(g[1]),
    .gate_low_phase_c_o(g[0]), .low_side_modulation_o(lsm), .brake_active_o(bact));
  function automatic logic [5:0] expect_g();
    logic [2:0] p;
    logic [3:0] mr;
    logic [5:0] e;
    p = dir ? hall : ~hall;
    e = 6'h00;
    mr = 4'h0;
    if (!brk_n) return bexp;
    if (p == 3'h0 || p == 3'h7) return e;
    case (p)
      3'h5: mr = 4'h2;
      3'h4: mr = 4'h6;
      3'h6: mr = 4'h4;
      3'h2: mr = 4'h8;
      3'h3: mr = 4'h9;
      default: mr = 4'h1;
    endcase
    if (!hlf) begin
      e[5 - 2 * mr[3:2]] = pwm;
      e[4 - 2 * mr[3:2]] = fw & ~pwm;
      e[4 - 2 * mr[1:0]] = 1'b1;
    end else begin
      e[4 - 2 * mr[1:0]] = pwm;
      e[5 - 2 * mr[1:0]] = fw & ~pwm;
      e[5 - 2 * mr[3:2]] = 1'b1;
    end
    return e;
  endfunction
  task automatic chk();
    repeat (12) @(negedge clk_i);
    `CHK(g, expect_g())
  endtask
  task automatic stp();
    step <= 1'b1;
    @(negedge clk_i);
    step <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      {fw, dir, pwm} <= 3'(i / 6);
      stp();
      chk();
    end
    bad <= 2'h1;
    chk();
    bad <= 2'h2;
    chk();
    bad <= 2'h0;
    {alt, fw, dir} <= 3'h7;
    for (int i = 1; i <= 13; i++) begin
      pwm <= i[0];
      fw <= i[1];
      dir <= i[2];
      hlf <= (i % 12) >= 6;
      stp();
      chk();
      `CHK(lsm, hlf)
    end
    for (int i = 0; i < 5; i++) begin
      bsel <= 2'(10'h31A >> (2 * i));
      bexp <= 6'(30'h0056_A56A >> (6 * i));
      brk_n <= 1'b0;
      chk();
      `CHK(bact, 1'b1)
      brk_n <= 1'b1;
      chk();
      `CHK(bact, 1'b0)
    end
    finish_test();
  end
endmodule // hall_commutation_alt_recirc_tb
`default_nettype wire
